// file: core/pifr_regs.sv
// Notes on behaviour
// - Hardware sets each flag on its event, regardless of any enable.
// - Writable hardware-set flags stay one until software writes zero.
// - Pulse unit 2 parameter flag is read-only OR of its status register.
// - Serial peripheral 2 summary flag is read-only OR of its flag register.
// - Serial peripheral 2 transmit and receive flags ignore writes, mirror buffer state.
// - Pulse unit 3 parameter flag is read-only OR of its status register.
// - Two-wire 1 error flag is read-only OR of its error register.
// - Two-wire 1 general flag is read-only OR of its protocol register.
// - Two-wire 1 transmit/receive flags are read-only; unit's buffer clear drops them.
// - Request 5 layout: pulse2 param, period, cell2, comparator2, serial2 summary/tx/rx.
// - Request 6 layout: DMA2 four flags, osc1, wavegen1, bit1 unused, ext1.
// - Request 7 layout: pulse3 param, period, cell3, bit4 unused, two-wire1 flags.
// - Request 8 layout: scanner, cell4, bits 6 and 4 unused, async2 flags.
// - Async unit 2 flags in request 8 are read-only, set by that unit.
// - Async 2 summary and framing flags clear when their unit registers clear.
// - Async 2 transmit and receive flags reject register writes.
// - Request register 5 sits at index 0x4b8, just below register 6.
`timescale 1ns/1ps
`default_nettype none

module pifr_regs #(
	parameter int STAT_W = pifr_pkg::PIFR_STAT_W
) (
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	// APB slave
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [pifr_pkg::PIFR_ADDR_W-1:0] paddr,
	input  wire logic [pifr_pkg::PIFR_DATA_W-1:0] pwdata,
	output logic      [pifr_pkg::PIFR_DATA_W-1:0] prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// Event pulses for request register 5
	input  wire logic                             pulse_unit2_period_set,
	input  wire logic                             logic_cell2_set,
	input  wire logic                             comparator2_set,
	// Level sources for request register 5
	input  wire logic [STAT_W-1:0]                pulse_unit2_irq_status,
	input  wire logic [STAT_W-1:0]                sp_unit2_irq_status,
	input  wire logic                             sp_unit2_tx_level,
	input  wire logic                             sp_unit2_rx_level,
	// Event pulses for request register 6
	input  wire logic                             dma_ch2_abort_set,
	input  wire logic                             dma_ch2_overrun_set,
	input  wire logic                             dma_ch2_dest_count_set,
	input  wire logic                             dma_ch2_src_count_set,
	input  wire logic                             osc_unit1_set,
	input  wire logic                             waveform_gen1_set,
	input  wire logic                             ext_irq1_set,
	// Request register 7 sources
	input  wire logic                             pulse_unit3_period_set,
	input  wire logic                             logic_cell3_set,
	input  wire logic [STAT_W-1:0]                pulse_unit3_irq_status,
	input  wire logic [STAT_W-1:0]                tw_unit1_error_reg,
	input  wire logic [STAT_W-1:0]                tw_unit1_protocol_irq_reg,
	input  wire logic                             tw_unit1_tx_level,
	input  wire logic                             tw_unit1_rx_level,
	// Request register 8 sources
	input  wire logic                             mem_scanner_set,
	input  wire logic                             logic_cell4_set,
	input  wire logic [STAT_W-1:0]                async_unit2_irq_reg,
	input  wire logic [STAT_W-1:0]                async_unit2_error_reg,
	input  wire logic                             async_unit2_tx_level,
	input  wire logic                             async_unit2_rx_level,
	// Register contents for the vectoring logic
	output logic      [pifr_pkg::PIFR_REG_W-1:0]  irq_request_5,
	output logic      [pifr_pkg::PIFR_REG_W-1:0]  irq_request_6,
	output logic      [pifr_pkg::PIFR_REG_W-1:0]  irq_request_7,
	output logic      [pifr_pkg::PIFR_REG_W-1:0]  irq_request_8,
	output logic                                  irq
);
	import pifr_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [3:0][7:0] hs_set;       // Hardware set pulses per slot
	logic [3:0][7:0] ro_src;       // Read-only mirror sources per slot
	logic [3:0][7:0] rw_q;         // Sticky flag outputs
	logic [3:0][7:0] ro_q;         // Registered mirrors
	logic [3:0][7:0] next_ro_q;
	logic [3:0][7:0] flags;        // Combined register view
	logic [3:0][7:0] flags_q;      // Previous view, for edge detect
	logic [3:0]      req_wr;       // Write strobe per slot
	logic [31:0]     evt_status;
	logic [31:0]     evt_mask;
	logic [31:0]     next_evt_status;
	logic [31:0]     next_evt_mask;
	logic [31:0]     flag_rise;
	logic [31:0]     next_prdata;
	logic            setup_ph;
	logic            access_ph;
	logic            wr_acc;
	logic            addr_hit;
	logic [3:0]      rd_slot;      // Request slot under the read address

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// Byte address of a register index
	function automatic logic [PIFR_ADDR_W-1:0] byte_addr(input logic [11:0] idx);
		byte_addr = {idx, PIFR_WORD_LSB};
	endfunction : byte_addr

	// Slot of a request register, one-hot, zero if none
	function automatic logic [3:0] req_slot(input logic [PIFR_ADDR_W-1:0] a);
		req_slot = 4'h0;
		if (a == byte_addr(PIFR_IDX_REQ5)) begin
			req_slot[PIFR_SLOT_REQ5] = 1'b1;
		end
		if (a == byte_addr(PIFR_IDX_REQ6)) begin
			req_slot[PIFR_SLOT_REQ6] = 1'b1;
		end
		if (a == byte_addr(PIFR_IDX_REQ7)) begin
			req_slot[PIFR_SLOT_REQ7] = 1'b1;
		end
		if (a == byte_addr(PIFR_IDX_REQ8)) begin
			req_slot[PIFR_SLOT_REQ8] = 1'b1;
		end
	endfunction : req_slot

	// Any mapped register
	function automatic logic is_mapped(input logic [PIFR_ADDR_W-1:0] a);
		is_mapped = (|req_slot(a))
			|| (a == byte_addr(PIFR_IDX_EVT_STATUS))
			|| (a == byte_addr(PIFR_IDX_EVT_MASK));
	endfunction : is_mapped

	// Bus phases and zero-wait answer
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign addr_hit  = is_mapped(paddr);
	assign wr_acc    = access_ph & pwrite;
	assign pready    = access_ph;
	assign pslverr   = access_ph & ~addr_hit;
	assign req_wr    = wr_acc ? req_slot(paddr) : 4'h0;
	assign rd_slot   = req_slot(paddr);

	// ----------------------------------------------------------------
	// Hardware set pulses
	// ----------------------------------------------------------------

	// Pulses routed to their bit positions
	always_comb begin
		hs_set = '0;
		hs_set[PIFR_SLOT_REQ5][PIFR_R5_PWM2_PERIOD] = pulse_unit2_period_set;
		hs_set[PIFR_SLOT_REQ5][PIFR_R5_CELL2]       = logic_cell2_set;
		hs_set[PIFR_SLOT_REQ5][PIFR_R5_CMP2]        = comparator2_set;
		hs_set[PIFR_SLOT_REQ6][PIFR_R6_DMA2_ABORT]  = dma_ch2_abort_set;
		hs_set[PIFR_SLOT_REQ6][PIFR_R6_DMA2_OVRUN]  = dma_ch2_overrun_set;
		hs_set[PIFR_SLOT_REQ6][PIFR_R6_DMA2_DCNT]   = dma_ch2_dest_count_set;
		hs_set[PIFR_SLOT_REQ6][PIFR_R6_DMA2_SCNT]   = dma_ch2_src_count_set;
		hs_set[PIFR_SLOT_REQ6][PIFR_R6_OSC1]        = osc_unit1_set;
		hs_set[PIFR_SLOT_REQ6][PIFR_R6_WAVE1]       = waveform_gen1_set;
		hs_set[PIFR_SLOT_REQ6][PIFR_R6_EXT1]        = ext_irq1_set;
		hs_set[PIFR_SLOT_REQ7][PIFR_R7_PWM3_PERIOD] = pulse_unit3_period_set;
		hs_set[PIFR_SLOT_REQ7][PIFR_R7_CELL3]       = logic_cell3_set;
		hs_set[PIFR_SLOT_REQ8][PIFR_R8_SCAN]        = mem_scanner_set;
		hs_set[PIFR_SLOT_REQ8][PIFR_R8_CELL4]       = logic_cell4_set;
	end

	// ----------------------------------------------------------------
	// Read-only mirror sources
	// ----------------------------------------------------------------

	// Summaries and buffer levels from the peripherals
	always_comb begin
		ro_src = '0;
		ro_src[PIFR_SLOT_REQ5][PIFR_R5_PWM2_PARAM] = |pulse_unit2_irq_status;
		ro_src[PIFR_SLOT_REQ5][PIFR_R5_SP2_SUM]    = |sp_unit2_irq_status;
		ro_src[PIFR_SLOT_REQ5][PIFR_R5_SP2_TX]     = sp_unit2_tx_level;
		ro_src[PIFR_SLOT_REQ5][PIFR_R5_SP2_RX]     = sp_unit2_rx_level;
		ro_src[PIFR_SLOT_REQ7][PIFR_R7_PWM3_PARAM] = |pulse_unit3_irq_status;
		ro_src[PIFR_SLOT_REQ7][PIFR_R7_TW1_ERR]    = |tw_unit1_error_reg;
		ro_src[PIFR_SLOT_REQ7][PIFR_R7_TW1_GEN]    = |tw_unit1_protocol_irq_reg;
		ro_src[PIFR_SLOT_REQ7][PIFR_R7_TW1_TX]     = tw_unit1_tx_level;
		ro_src[PIFR_SLOT_REQ7][PIFR_R7_TW1_RX]     = tw_unit1_rx_level;
		ro_src[PIFR_SLOT_REQ8][PIFR_R8_AS2_SUM]    = |async_unit2_irq_reg;
		ro_src[PIFR_SLOT_REQ8][PIFR_R8_AS2_FRAME]  = |async_unit2_error_reg;
		ro_src[PIFR_SLOT_REQ8][PIFR_R8_AS2_TX]     = async_unit2_tx_level;
		ro_src[PIFR_SLOT_REQ8][PIFR_R8_AS2_RX]     = async_unit2_rx_level;
	end

	// Mirrors follow their source only; bus writes never reach them
	always_comb begin
		for (int r = 0; r < PIFR_NUM_REQ; r++) begin
			next_ro_q[r] = ro_src[r] & PIFR_RO_MASK[r];
		end
	end

	// Mirror storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int r = 0; r < PIFR_NUM_REQ; r++) begin
				ro_q[r] <= PIFR_REQ_RESET;
			end
		end else begin
			ro_q <= next_ro_q;
		end
	end

	// ----------------------------------------------------------------
	// Sticky flags
	// ----------------------------------------------------------------

	// One sticky flag per writable bit, unused bits held at zero
	for (genvar r = 0; r < PIFR_NUM_REQ; r++) begin : g_reg
		for (genvar b = 0; b < PIFR_REG_W; b++) begin : g_bit
			if (PIFR_RW_MASK[r][b]) begin : g_rw
				pifr_sticky_flag u_flag (
					.pclk    (pclk),
					.presetn (presetn),
					.hw_set  (hs_set[r][b]),
					.sw_wr   (req_wr[r]),
					.sw_data (pwdata[b]),
					.flag    (rw_q[r][b])
				);
			end else begin : g_ro
				assign rw_q[r][b] = 1'b0;
			end
		end
	end

	// Combined view of the four request registers
	assign flags         = rw_q | ro_q;
	assign irq_request_5 = flags[PIFR_SLOT_REQ5];
	assign irq_request_6 = flags[PIFR_SLOT_REQ6];
	assign irq_request_7 = flags[PIFR_SLOT_REQ7];
	assign irq_request_8 = flags[PIFR_SLOT_REQ8];

	// ----------------------------------------------------------------
	// Event status and mask
	// ----------------------------------------------------------------

	// Any flag rising from zero to one
	assign flag_rise = flags & ~flags_q;

	// Status bits are write-one-to-clear; a new rise wins
	always_comb begin
		next_evt_status = evt_status;
		next_evt_mask   = evt_mask;
		if (wr_acc && (paddr == byte_addr(PIFR_IDX_EVT_STATUS))) begin
			next_evt_status = evt_status & ~pwdata;
		end
		if (wr_acc && (paddr == byte_addr(PIFR_IDX_EVT_MASK))) begin
			next_evt_mask = pwdata;
		end
		next_evt_status = next_evt_status | flag_rise;
	end

	// Status, mask and edge history storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_status <= PIFR_EVT_RESET;
			evt_mask   <= PIFR_MASK_RESET;
			flags_q    <= PIFR_EVT_RESET;
		end else begin
			evt_status <= next_evt_status;
			evt_mask   <= next_evt_mask;
			flags_q    <= flags;
		end
	end

	// Level interrupt from unmasked status
	assign irq = |(evt_status & evt_mask);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Read word captured in the setup phase, held through access
	always_comb begin
		next_prdata = prdata;
		if (setup_ph) begin
			next_prdata = PIFR_RDATA_ZERO;
			for (int r = 0; r < PIFR_NUM_REQ; r++) begin
				if (rd_slot[r]) begin
					next_prdata[PIFR_REG_W-1:0] = flags[r];
				end
			end
			if (paddr == byte_addr(PIFR_IDX_EVT_STATUS)) begin
				next_prdata = evt_status;
			end
			if (paddr == byte_addr(PIFR_IDX_EVT_MASK)) begin
				next_prdata = evt_mask;
			end
		end
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= PIFR_RDATA_ZERO;
		end else begin
			prdata <= next_prdata;
		end
	end

endmodule : pifr_regs

`default_nettype wire

// file: include/pifr_pkg.sv
package pifr_pkg;

	// ----------------------------------------------------------------
	// Bus and register geometry
	// ----------------------------------------------------------------
	localparam int          PIFR_DATA_W   = 32;
	localparam int          PIFR_ADDR_W   = 14;
	localparam int          PIFR_IDX_W    = 12;
	localparam int          PIFR_REG_W    = 8;
	localparam int          PIFR_NUM_REQ  = 4;
	localparam int          PIFR_EVT_W    = PIFR_NUM_REQ * PIFR_REG_W;
	localparam int          PIFR_STAT_W   = 8;

	// Register indices; byte address is four times the index
	localparam logic [11:0] PIFR_IDX_REQ5       = 12'h4b8;
	localparam logic [11:0] PIFR_IDX_REQ6       = 12'h4b9;
	localparam logic [11:0] PIFR_IDX_REQ7       = 12'h4ba;
	localparam logic [11:0] PIFR_IDX_REQ8       = 12'h4bb;
	localparam logic [11:0] PIFR_IDX_EVT_STATUS = 12'h4c0;
	localparam logic [11:0] PIFR_IDX_EVT_MASK   = 12'h4c1;
	localparam logic [1:0]  PIFR_WORD_LSB       = 2'h0;

	// Slots of the request bank, slot 0 is request register 5
	localparam int          PIFR_SLOT_REQ5 = 0;
	localparam int          PIFR_SLOT_REQ6 = 1;
	localparam int          PIFR_SLOT_REQ7 = 2;
	localparam int          PIFR_SLOT_REQ8 = 3;

	// Software-writable, hardware-set bits of each register
	localparam logic [3:0][7:0] PIFR_RW_MASK = {8'ha0, 8'h60, 8'hfd, 8'h70};
	// Read-only mirror bits of each register
	localparam logic [3:0][7:0] PIFR_RO_MASK = {8'h0f, 8'h8f, 8'h00, 8'h87};

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  PIFR_REQ_RESET  = 8'h00;
	localparam logic [31:0] PIFR_EVT_RESET  = 32'h0000_0000;
	localparam logic [31:0] PIFR_MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] PIFR_RDATA_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Bit positions, request register 5
	// ----------------------------------------------------------------
	localparam int PIFR_R5_PWM2_PARAM  = 7;
	localparam int PIFR_R5_PWM2_PERIOD = 6;
	localparam int PIFR_R5_CELL2       = 5;
	localparam int PIFR_R5_CMP2        = 4;
	localparam int PIFR_R5_SP2_SUM     = 2;
	localparam int PIFR_R5_SP2_TX      = 1;
	localparam int PIFR_R5_SP2_RX      = 0;

	// Request register 6
	localparam int PIFR_R6_DMA2_ABORT  = 7;
	localparam int PIFR_R6_DMA2_OVRUN  = 6;
	localparam int PIFR_R6_DMA2_DCNT   = 5;
	localparam int PIFR_R6_DMA2_SCNT   = 4;
	localparam int PIFR_R6_OSC1        = 3;
	localparam int PIFR_R6_WAVE1       = 2;
	localparam int PIFR_R6_EXT1        = 0;

	// Request register 7
	localparam int PIFR_R7_PWM3_PARAM  = 7;
	localparam int PIFR_R7_PWM3_PERIOD = 6;
	localparam int PIFR_R7_CELL3       = 5;
	localparam int PIFR_R7_TW1_ERR     = 3;
	localparam int PIFR_R7_TW1_GEN     = 2;
	localparam int PIFR_R7_TW1_TX      = 1;
	localparam int PIFR_R7_TW1_RX      = 0;

	// Request register 8
	localparam int PIFR_R8_SCAN        = 7;
	localparam int PIFR_R8_CELL4       = 5;
	localparam int PIFR_R8_AS2_SUM     = 3;
	localparam int PIFR_R8_AS2_FRAME   = 2;
	localparam int PIFR_R8_AS2_TX      = 1;
	localparam int PIFR_R8_AS2_RX      = 0;

endpackage : pifr_pkg

// file: core/pifr_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none

// One hardware-set, software-written flag
module pifr_sticky_flag (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic hw_set,
	input  wire logic sw_wr,
	input  wire logic sw_data,
	output logic      flag
);

	logic next_flag;

	// ----------------------------------------------------------------
	// Flag update
	// ----------------------------------------------------------------

	// Hardware set wins over a software write of zero
	always_comb begin
		next_flag = flag;
		if (sw_wr) begin
			next_flag = sw_data;
		end
		if (hw_set) begin
			next_flag = 1'b1;
		end
	end

	// Flag storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end

endmodule : pifr_sticky_flag

`default_nettype wire

// file: verification/pifr_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checks of the request flag bank
// ----------------------------------------
module pifr_regs_chk #(
	parameter int STAT_W = 8
) (
	input wire logic                             pclk,
	input wire logic                             presetn,
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pwrite,
	input wire logic [pifr_pkg::PIFR_ADDR_W-1:0] paddr,
	input wire logic                             ext_irq1_set,
	input wire logic [STAT_W-1:0]                pulse_unit2_irq_status,
	input wire logic [STAT_W-1:0]                sp_unit2_irq_status,
	input wire logic                             sp_unit2_tx_level,
	input wire logic                             sp_unit2_rx_level,
	input wire logic [STAT_W-1:0]                tw_unit1_error_reg,
	input wire logic [STAT_W-1:0]                tw_unit1_protocol_irq_reg,
	input wire logic                             tw_unit1_tx_level,
	input wire logic                             tw_unit1_rx_level,
	input wire logic [STAT_W-1:0]                async_unit2_irq_reg,
	input wire logic [STAT_W-1:0]                async_unit2_error_reg,
	input wire logic                             async_unit2_tx_level,
	input wire logic                             async_unit2_rx_level,
	input wire logic [pifr_pkg::PIFR_REG_W-1:0]  irq_request_5,
	input wire logic [pifr_pkg::PIFR_REG_W-1:0]  irq_request_6,
	input wire logic [pifr_pkg::PIFR_REG_W-1:0]  irq_request_7,
	input wire logic [pifr_pkg::PIFR_REG_W-1:0]  irq_request_8
);
	import pifr_pkg::*;
	localparam logic [13:0] A6 = {PIFR_IDX_REQ6, PIFR_WORD_LSB};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ext_set_next: assert property (ext_irq1_set |=> irq_request_6[0])
		else $error("ext flag missed its event");
	a_ext_sticky: assert property (irq_request_6[0] && !(psel && penable && pwrite && paddr == A6)
		|=> irq_request_6[0]) else $error("ext flag dropped without a write");
	a_ext_rise_cause: assert property ($rose(irq_request_6[0]) |-> $past(ext_irq1_set)
		|| $past(psel && penable && pwrite && paddr == A6)) else $error("ext flag rose alone");
	a_pw2_mirror: assert property (irq_request_5[7] == $past(|pulse_unit2_irq_status))
		else $error("pulse 2 summary wrong");
	a_sp2_mirror: assert property (irq_request_5[2:0] == $past({|sp_unit2_irq_status,
		sp_unit2_tx_level, sp_unit2_rx_level})) else $error("serial 2 flags wrong");
	a_tw1_mirror: assert property (irq_request_7[3:0] == $past({|tw_unit1_error_reg,
		|tw_unit1_protocol_irq_reg, tw_unit1_tx_level, tw_unit1_rx_level}))
		else $error("two-wire flags wrong");
	a_as2_mirror: assert property (irq_request_8[3:0] == $past({|async_unit2_irq_reg,
		|async_unit2_error_reg, async_unit2_tx_level, async_unit2_rx_level}))
		else $error("async 2 flags wrong");
	a_unused_zero: assert property ({irq_request_5[3], irq_request_6[1], irq_request_7[4],
		irq_request_8[6], irq_request_8[4]} == 5'h0) else $error("unused bit set");
endmodule : pifr_regs_chk

bind pifr_regs pifr_regs_chk #(.STAT_W(STAT_W)) pifr_regs_chk_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .ext_irq1_set,
	.pulse_unit2_irq_status, .sp_unit2_irq_status, .sp_unit2_tx_level, .sp_unit2_rx_level,
	.tw_unit1_error_reg, .tw_unit1_protocol_irq_reg, .tw_unit1_tx_level, .tw_unit1_rx_level,
	.async_unit2_irq_reg, .async_unit2_error_reg, .async_unit2_tx_level,
	.async_unit2_rx_level, .irq_request_5, .irq_request_6, .irq_request_7, .irq_request_8
);

`default_nettype wire

// file: verification/pifr_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

// Peripheral side: event strobes, status registers, buffer levels
module pifr_periph_model (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic [13:0]     fire,
	input  wire logic [6:0][7:0] stat,
	input  wire logic [5:0]      lvl,
	input  wire logic            buf_clr,
	output logic      [13:0]     set_o,
	output logic      [6:0][7:0] stat_o,
	output logic      [5:0]      lvl_o
);
	// Launched just after the edge, whatever the enables are
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_o  <= '0;
			stat_o <= '0;
			lvl_o  <= '0;
		end else begin
			set_o  <= fire;
			stat_o <= stat;
			lvl_o  <= lvl & ~{2'h0, {2{buf_clr}}, 2'h0};
		end
	end
endmodule : pifr_periph_model

`default_nettype wire

// file: verification/peripheral_irq_flag_regs_5_to_8_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end

module peripheral_irq_flag_regs_5_to_8_bench;
	import pifr_pkg::*;
	localparam logic [11:0] RIDX [4] = '{PIFR_IDX_REQ5, PIFR_IDX_REQ6, PIFR_IDX_REQ7, PIFR_IDX_REQ8};
	localparam logic [7:0]  WMASK[4] = '{8'h70, 8'hfd, 8'h60, 8'ha0};
	localparam logic [7:0]  MIR  [4] = '{8'h87, 8'h00, 8'h8f, 8'h0f};
	logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, buf_clr;
	logic [13:0]     paddr, fire, set_w;
	logic [31:0]     pwdata, prdata;
	logic [7:0]      r5, r6, r7, r8;
	logic [6:0][7:0] stat, stat_w;
	logic [5:0]      lvl, lvl_w;
	logic [32:0]     expq[$];
	logic [32:0]     exp_v;
	int              mismatches, compares;

	pifr_periph_model pifr_periph_model_inst (.pclk, .presetn, .fire, .stat, .lvl, .buf_clr,
		.set_o(set_w), .stat_o(stat_w), .lvl_o(lvl_w));
	pifr_regs pifr_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .irq_request_5(r5), .irq_request_6(r6),
		.irq_request_7(r7), .irq_request_8(r8), .pulse_unit2_period_set(set_w[0]),
		.logic_cell2_set(set_w[1]), .comparator2_set(set_w[2]), .dma_ch2_abort_set(set_w[3]),
		.dma_ch2_overrun_set(set_w[4]), .dma_ch2_dest_count_set(set_w[5]),
		.dma_ch2_src_count_set(set_w[6]), .osc_unit1_set(set_w[7]),
		.waveform_gen1_set(set_w[8]), .ext_irq1_set(set_w[9]),
		.pulse_unit3_period_set(set_w[10]), .logic_cell3_set(set_w[11]),
		.mem_scanner_set(set_w[12]), .logic_cell4_set(set_w[13]),
		.pulse_unit2_irq_status(stat_w[0]), .sp_unit2_irq_status(stat_w[1]),
		.pulse_unit3_irq_status(stat_w[2]), .tw_unit1_error_reg(stat_w[3]),
		.tw_unit1_protocol_irq_reg(stat_w[4]), .async_unit2_irq_reg(stat_w[5]),
		.async_unit2_error_reg(stat_w[6]), .sp_unit2_tx_level(lvl_w[0]),
		.sp_unit2_rx_level(lvl_w[1]), .tw_unit1_tx_level(lvl_w[2]),
		.tw_unit1_rx_level(lvl_w[3]), .async_unit2_tx_level(lvl_w[4]),
		.async_unit2_rx_level(lvl_w[5]));

	// 20 MHz clock
	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end

	task automatic end_of_test();
		if (mismatches == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	// One APB transfer; reads leave their expectation in the queue
	task automatic apb(input logic [11:0] idx, input logic wr, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= {idx, PIFR_WORD_LSB};
		pwdata  <= d;
		if (!wr) begin
			expq.push_back(e);
		end
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1) begin
			mismatches++;
			end_of_test();
		end
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		apb(idx, 1'h1, d, 33'h0);
	endtask : wr

	task automatic rd(input logic [11:0] idx, input logic [31:0] e);
		apb(idx, 1'h0, 32'h0, {1'h0, e});
	endtask : rd

	task automatic pulse(input logic [13:0] v);
		@(posedge pclk);
		fire <= v;
		@(posedge pclk);
		fire <= 14'h0;
		repeat (3) @(posedge pclk);
	endtask : pulse

	task automatic chk_irq(input logic e);
		@(negedge pclk);
		`CHK("irq", e, irq)
	endtask : chk_irq

	// Completed reads against the oldest expectation
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			exp_v = (expq.size() > 0) ? expq.pop_front() : 33'h1_0bad_0bad;
			`CHK("read", exp_v, {pslverr, prdata})
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, buf_clr} = 5'h0;
		{paddr, fire, pwdata, stat, lvl} = '0;
		mismatches = 0;
		compares = 0;
		void'($urandom(98));
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 4; i++) rd(RIDX[i], 32'h0);
		rd(PIFR_IDX_EVT_STATUS, 32'h0);
		apb(12'h4bf, 1'h0, 32'h0, {1'h1, 32'h0});
		pulse(14'h3fff);
		chk_irq(1'h0);
		for (int i = 0; i < 4; i++) rd(RIDX[i], {24'h0, WMASK[i]});
		for (int i = 0; i < 4; i++) begin
			wr(RIDX[i], 32'h0);
			rd(RIDX[i], 32'h0);
			wr(RIDX[i], 32'hffff_ffff);
			rd(RIDX[i], {24'h0, WMASK[i]});
			wr(RIDX[i], 32'h0);
		end
		@(posedge pclk);
		for (int k = 0; k < 7; k++) stat[k] <= 8'h01 << ($urandom % 8);
		lvl <= 6'h3f;
		repeat (3) @(posedge pclk);
		for (int i = 0; i < 4; i++) wr(RIDX[i], 32'h0);
		for (int i = 0; i < 4; i++) rd(RIDX[i], {24'h0, MIR[i]});
		buf_clr <= 1'h1;
		@(posedge pclk); // Model and mirror each add one edge
		rd(PIFR_IDX_REQ7, 32'h8c);
		stat <= '0;
		lvl <= 6'h0;
		buf_clr <= 1'h0;
		@(posedge pclk); // Model and mirror each add one edge
		for (int i = 0; i < 4; i++) rd(RIDX[i], 32'h0);
		wr(PIFR_IDX_REQ6, 32'h0);
		wr(PIFR_IDX_EVT_STATUS, 32'hffff_ffff);
		rd(PIFR_IDX_EVT_STATUS, 32'h0);
		wr(PIFR_IDX_EVT_MASK, 32'h100);
		chk_irq(1'h0);
		pulse(14'h0200);
		chk_irq(1'h1);
		rd(PIFR_IDX_EVT_STATUS, 32'h100);
		wr(PIFR_IDX_EVT_MASK, 32'h0);
		chk_irq(1'h0);
		wr(PIFR_IDX_EVT_MASK, 32'h100);
		chk_irq(1'h1);
		wr(PIFR_IDX_REQ6, 32'h0);
		rd(PIFR_IDX_REQ6, 32'h0);
		wr(PIFR_IDX_EVT_STATUS, 32'h100);
		chk_irq(1'h0);
		end_of_test();
	end
endmodule : peripheral_irq_flag_regs_5_to_8_bench

`default_nettype wire
